// file: core/sdes_pkg.sv
// Constants and types shared by the drop event status block
// Function
// [R1] Two independent capture sets hold two drops
// [R2] Every drop interrupt source is maskable
// [R3] Bit 0 pending sets on drop, read clears
// [R4] Bit 1 flags set A valid, read clears
// [R5] Set A: reason 7:4, port 3:2, read clear
// [R6] Bit 8 flags set B valid, read clears
// [R7] Set B: reason 14:11, port 10:9; upper zero
// [R8] Port codes 00,01,10; 11 never reported
// [R9] Code 0000: tagged-only admit, untagged packet
// [R10] Codes 0001/0101: source not VLAN member
// [R11] Codes 0010/0011: source/destination not forwarding
// [R12] Code 0100: found destination not VLAN member
// [R13] Codes 0110/0111: unknown unicast/multicast discard
// [R14] Code 1000: broadcast over rate limit
// [R15] Code 1001: unknown destination, source not forwarding
// [R16] Codes 1010/1011: same port, filter bit
// [R17] Code 1110 for VLAN FFFh; others reserved
// [R18] Mask bit defaults set, leaves status alone
// [R19] Fill A first, then B; else pending only
package sdes_pkg;
  typedef logic [3:0] sdes_reason_type; // Drop reason code
  typedef logic [1:0] sdes_port_type; // Source port code
  // Register indexes; byte address is four times the index
  localparam logic [15:0] SDES_IDX_MASK = 16'h1880;
  localparam logic [15:0] SDES_IDX_STATUS = 16'h1881;
  localparam logic [15:0] SDES_IDX_EVT = 16'h1882;
  localparam logic [15:0] SDES_IDX_EVT_CLR = 16'h1883;
  localparam logic [15:0] SDES_IDX_EVT_EN = 16'h1884;
  localparam logic [15:0] SDES_ADDR_MASK = {SDES_IDX_MASK[13:0], 2'h0};
  localparam logic [15:0] SDES_ADDR_STATUS = {SDES_IDX_STATUS[13:0], 2'h0};
  localparam logic [15:0] SDES_ADDR_EVT = {SDES_IDX_EVT[13:0], 2'h0};
  localparam logic [15:0] SDES_ADDR_EVT_CLR = {SDES_IDX_EVT_CLR[13:0], 2'h0};
  localparam logic [15:0] SDES_ADDR_EVT_EN = {SDES_IDX_EVT_EN[13:0], 2'h0};
  // Field positions of the status word
  localparam int SDES_BIT_PEND = 0;
  localparam int SDES_BIT_A_VALID = 1;
  localparam int SDES_LSB_A_PORT = 2;
  localparam int SDES_LSB_A_REASON = 4;
  localparam int SDES_BIT_B_VALID = 8;
  localparam int SDES_LSB_B_PORT = 9;
  localparam int SDES_LSB_B_REASON = 11;
  localparam int SDES_USED_BITS = 15;
  // Event status bits: 0 captured, 1 lost
  localparam int SDES_EVT_CAPT = 0;
  localparam int SDES_EVT_LOST = 1;
  // Reset values
  localparam logic SDES_MASK_RST = 1'h1;
  localparam logic [1:0] SDES_EVT_EN_RST = 2'h3;
  localparam logic [1:0] SDES_EVT_RST = 2'h0;
  // Port codes
  localparam sdes_port_type SDES_PORT_RSVD = 2'h3;
  // Reason codes
  localparam sdes_reason_type SDES_RSN_UNTAGGED = 4'h0;
  localparam sdes_reason_type SDES_RSN_UNK_SRC_NONMEM = 4'h1;
  localparam sdes_reason_type SDES_RSN_SRC_NOFWD = 4'h2;
  localparam sdes_reason_type SDES_RSN_DST_NOFWD = 4'h3;
  localparam sdes_reason_type SDES_RSN_DST_NONMEM = 4'h4;
  localparam sdes_reason_type SDES_RSN_KNOWN_SRC_NONMEM = 4'h5;
  localparam sdes_reason_type SDES_RSN_UNK_UNICAST = 4'h6;
  localparam sdes_reason_type SDES_RSN_UNK_MULTICAST = 4'h7;
  localparam sdes_reason_type SDES_RSN_BCAST_LIMIT = 4'h8;
  localparam sdes_reason_type SDES_RSN_UNK_SRC_NOFWD = 4'h9;
  localparam sdes_reason_type SDES_RSN_SAME_PORT = 4'hA;
  localparam sdes_reason_type SDES_RSN_FILTER = 4'hB;
  localparam sdes_reason_type SDES_RSN_VLAN_FFF = 4'hE;
endpackage

// file: core/sdes_reason_enc.sv
// Drop reason encoder: turns drop conditions into a reason code
`timescale 1ns/1ps
module sdes_reason_enc (
  input wire logic tagged_only_admit,
  input wire logic ingress_member_check,
  input wire logic nonmember_admit,
  input wire logic unknown_unicast_discard,
  input wire logic unknown_multicast_discard,
  input wire logic untagged_or_prio,
  input wire logic vlan_id_fff,
  input wire logic pkt_bcast,
  input wire logic pkt_mcast,
  input wire logic bcast_over_limit,
  input wire logic dst_found,
  input wire logic src_forwarding,
  input wire logic dst_forwarding,
  input wire logic src_in_vlan,
  input wire logic dst_in_vlan,
  input wire logic same_port,
  input wire logic entry_filter,
  output sdes_pkg::sdes_reason_type code,
  output logic known
);
  logic unknown_path; // Destination unknown or broadcast
  logic src_nonmember; // Source fails the ingress membership check
  assign unknown_path = ~dst_found | pkt_bcast;
  assign src_nonmember = ingress_member_check & ~nonmember_admit & ~src_in_vlan;
  // Fixed priority; the reserved codes can never come out of this
  always_comb
  begin
    code = sdes_pkg::SDES_RSN_UNTAGGED;
    known = 1'b1;
    if (vlan_id_fff)
      code = sdes_pkg::SDES_RSN_VLAN_FFF; // [R17]
    else if (tagged_only_admit & untagged_or_prio)
      code = sdes_pkg::SDES_RSN_UNTAGGED; // [R9]
    else if (pkt_bcast & bcast_over_limit)
      code = sdes_pkg::SDES_RSN_BCAST_LIMIT; // [R14]
    else if (unknown_path)
    begin
      if (src_nonmember)
        code = sdes_pkg::SDES_RSN_UNK_SRC_NONMEM; // [R10]
      else if (~src_forwarding)
        code = sdes_pkg::SDES_RSN_UNK_SRC_NOFWD; // [R15]
      else if (unknown_unicast_discard & ~pkt_mcast & ~pkt_bcast)
        code = sdes_pkg::SDES_RSN_UNK_UNICAST; // [R13]
      else if (unknown_multicast_discard & pkt_mcast & ~pkt_bcast)
        code = sdes_pkg::SDES_RSN_UNK_MULTICAST; // [R13]
      else
        known = 1'b0; // No documented cause
    end
    else
    begin
      if (~src_forwarding)
        code = sdes_pkg::SDES_RSN_SRC_NOFWD; // [R11]
      else if (~dst_forwarding)
        code = sdes_pkg::SDES_RSN_DST_NOFWD; // [R11]
      else if (src_nonmember)
        code = sdes_pkg::SDES_RSN_KNOWN_SRC_NONMEM; // [R10]
      else if (ingress_member_check & ~dst_in_vlan)
        code = sdes_pkg::SDES_RSN_DST_NONMEM; // [R12]
      else if (same_port)
        code = sdes_pkg::SDES_RSN_SAME_PORT; // [R16]
      else if (entry_filter)
        code = sdes_pkg::SDES_RSN_FILTER; // [R16]
      else
        known = 1'b0; // No documented cause
    end
  end
endmodule // sdes_reason_enc

// file: core/sdes_capture_set.sv
// One capture set: valid flag, reason and source port
`timescale 1ns/1ps
module sdes_capture_set (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic load,
  input sdes_pkg::sdes_reason_type reason_in,
  input sdes_pkg::sdes_port_type port_in,
  output logic valid_reg,
  output sdes_pkg::sdes_reason_type reason_reg,
  output sdes_pkg::sdes_port_type port_reg
);
  // Load beats clear so a drop in the read cycle is kept
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      valid_reg <= 1'b0;
      reason_reg <= 4'h0;
      port_reg <= 2'h0;
    end
    else if (load)
    begin
      valid_reg <= 1'b1;
      reason_reg <= reason_in;
      port_reg <= port_in;
    end
    else if (clr)
    begin
      valid_reg <= 1'b0;
      reason_reg <= 4'h0;
      port_reg <= 2'h0;
    end
  end
endmodule // sdes_capture_set

// file: core/sdes_top.sv
// Drop event status block: two capture sets, register port and interrupt
`timescale 1ns/1ps
module sdes_top (
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [15:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ,
  // Drop report from the forwarding engine, same clock
  input wire logic DROP_VALID,
  input wire logic [1:0] DROP_SRC_PORT,
  // Switch configuration
  input wire logic TAGGED_ONLY_ADMIT,
  input wire logic INGRESS_MEMBER_CHECK,
  input wire logic NONMEMBER_ADMIT,
  input wire logic UNKNOWN_UNICAST_DISCARD,
  input wire logic UNKNOWN_MULTICAST_DISCARD,
  // Packet and lookup facts for the dropped packet
  input wire logic PKT_UNTAGGED_OR_PRIO,
  input wire logic PKT_VLAN_ID_FFF,
  input wire logic PKT_BCAST,
  input wire logic PKT_MCAST,
  input wire logic BCAST_OVER_LIMIT,
  input wire logic DST_FOUND,
  input wire logic SRC_FORWARDING,
  input wire logic DST_FORWARDING,
  input wire logic SRC_IN_VLAN,
  input wire logic DST_IN_VLAN,
  input wire logic SAME_PORT,
  input wire logic ENTRY_FILTER
);
  // Address compare, shared by the read and write decode
  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
    addr_hit = (addr == target);
  endfunction

  sdes_pkg::sdes_reason_type drop_code; // Encoded reason of the current drop
  logic drop_known; // Drop has a documented cause
  logic capturable; // Drop can go into a set
  logic status_rd; // Read of the status word this cycle
  logic a_eff; // Set A still valid after this cycle's read clear
  logic b_eff; // Set B still valid after this cycle's read clear
  logic load_a; // Capture into set A
  logic load_b; // Capture into set B
  logic drop_lost; // Drop with no room or no reportable code
  logic a_valid; // Set A valid flag
  logic b_valid; // Set B valid flag
  sdes_pkg::sdes_reason_type a_reason; // Set A reason
  sdes_pkg::sdes_reason_type b_reason; // Set B reason
  sdes_pkg::sdes_port_type a_port; // Set A source port
  sdes_pkg::sdes_port_type b_port; // Set B source port
  logic pend_reg; // Summary pending bit
  logic mask_reg; // Engine interrupt mask
  logic [1:0] evt_reg; // Sticky interrupt events
  logic [1:0] evt_next; // Next value of the sticky events
  logic [1:0] evt_en_reg; // Event enables
  logic [31:0] status_word; // Assembled status word
  logic [31:0] rdata_reg; // Read data, valid one cycle after the strobe
  logic [31:0] rdata_next; // Read data to be registered

  // Turn the packet facts into a reason code
  sdes_reason_enc u_enc (
    .tagged_only_admit(TAGGED_ONLY_ADMIT),
    .ingress_member_check(INGRESS_MEMBER_CHECK),
    .nonmember_admit(NONMEMBER_ADMIT),
    .unknown_unicast_discard(UNKNOWN_UNICAST_DISCARD),
    .unknown_multicast_discard(UNKNOWN_MULTICAST_DISCARD),
    .untagged_or_prio(PKT_UNTAGGED_OR_PRIO),
    .vlan_id_fff(PKT_VLAN_ID_FFF),
    .pkt_bcast(PKT_BCAST),
    .pkt_mcast(PKT_MCAST),
    .bcast_over_limit(BCAST_OVER_LIMIT),
    .dst_found(DST_FOUND),
    .src_forwarding(SRC_FORWARDING),
    .dst_forwarding(DST_FORWARDING),
    .src_in_vlan(SRC_IN_VLAN),
    .dst_in_vlan(DST_IN_VLAN),
    .same_port(SAME_PORT),
    .entry_filter(ENTRY_FILTER),
    .code(drop_code),
    .known(drop_known)
  );

  // Reserved port code never reaches a set; the drop flags pending and the lost event
  assign capturable = DROP_VALID & drop_known
    & (DROP_SRC_PORT != sdes_pkg::SDES_PORT_RSVD); // [R8]

  // Reading the status word clears every field in it
  assign status_rd = RD & addr_hit(ADDR, sdes_pkg::SDES_ADDR_STATUS);

  // Occupancy as seen after the read clear, so a read and a drop in
  // the same cycle leave the new drop in set A
  assign a_eff = a_valid & ~status_rd;
  assign b_eff = b_valid & ~status_rd;

  // Fill order: A first, then B, otherwise nothing is stored
  assign load_a = capturable & ~a_eff; // [R19]
  assign load_b = capturable & a_eff & ~b_eff; // [R19] [R1]
  assign drop_lost = DROP_VALID & ~load_a & ~load_b;

  // Capture set A
  sdes_capture_set u_set_a (
    .clk(CLK),
    .rst_n(RST_N),
    .clr(status_rd),
    .load(load_a),
    .reason_in(drop_code),
    .port_in(DROP_SRC_PORT),
    .valid_reg(a_valid),
    .reason_reg(a_reason),
    .port_reg(a_port)
  );

  // Capture set B, independent of A
  sdes_capture_set u_set_b (
    .clk(CLK),
    .rst_n(RST_N),
    .clr(status_rd),
    .load(load_b),
    .reason_in(drop_code),
    .port_in(DROP_SRC_PORT),
    .valid_reg(b_valid),
    .reason_reg(b_reason),
    .port_reg(b_port)
  );

  // Summary pending bit; a drop in the read cycle wins over the clear
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      pend_reg <= 1'b0;
    else if (DROP_VALID)
      pend_reg <= 1'b1; // [R3]
    else if (status_rd)
      pend_reg <= 1'b0; // [R3]
  end

  // Engine mask; only gates the output, never touches status
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      mask_reg <= sdes_pkg::SDES_MASK_RST; // [R18]
    else if (WR && addr_hit(ADDR, sdes_pkg::SDES_ADDR_MASK))
      mask_reg <= WDATA[0];
  end

  // Event enables
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      evt_en_reg <= sdes_pkg::SDES_EVT_EN_RST;
    else if (WR && addr_hit(ADDR, sdes_pkg::SDES_ADDR_EVT_EN))
      evt_en_reg <= WDATA[1:0];
  end

  // Sticky events: write-one-to-clear, a new event wins over the clear
  always_comb
  begin
    evt_next = evt_reg;
    if (WR && addr_hit(ADDR, sdes_pkg::SDES_ADDR_EVT_CLR))
      evt_next = evt_next & ~WDATA[1:0];
    evt_next[sdes_pkg::SDES_EVT_CAPT] = evt_next[sdes_pkg::SDES_EVT_CAPT] | load_a | load_b;
    evt_next[sdes_pkg::SDES_EVT_LOST] = evt_next[sdes_pkg::SDES_EVT_LOST] | drop_lost;
  end

  // Event register
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      evt_reg <= sdes_pkg::SDES_EVT_RST;
    else
      evt_reg <= evt_next;
  end

  // One level output; the mask holds every source back
  assign IRQ = ~mask_reg & (|(evt_reg & evt_en_reg)); // [R2]

  // Status word layout, upper bits tied to zero
  always_comb
  begin
    status_word = 32'h0; // [R7]
    status_word[sdes_pkg::SDES_BIT_PEND] = pend_reg; // [R3]
    status_word[sdes_pkg::SDES_BIT_A_VALID] = a_valid; // [R4]
    status_word[sdes_pkg::SDES_LSB_A_PORT +: 2] = a_port; // [R5]
    status_word[sdes_pkg::SDES_LSB_A_REASON +: 4] = a_reason; // [R5]
    status_word[sdes_pkg::SDES_BIT_B_VALID] = b_valid; // [R6]
    status_word[sdes_pkg::SDES_LSB_B_PORT +: 2] = b_port; // [R7]
    status_word[sdes_pkg::SDES_LSB_B_REASON +: 4] = b_reason; // [R7]
  end

  // Read mux; unmapped and write-only addresses read as zero
  always_comb
  begin
    rdata_next = 32'h0;
    if (RD)
    begin
      case (ADDR)
        sdes_pkg::SDES_ADDR_STATUS: rdata_next = status_word;
        sdes_pkg::SDES_ADDR_MASK: rdata_next = {31'h0, mask_reg};
        sdes_pkg::SDES_ADDR_EVT: rdata_next = {30'h0, evt_reg};
        sdes_pkg::SDES_ADDR_EVT_EN: rdata_next = {30'h0, evt_en_reg};
        default: rdata_next = 32'h0;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      rdata_reg <= 32'h0;
    else
      rdata_reg <= rdata_next;
  end

  assign RDATA = rdata_reg;

  // Checks on the block's own behaviour
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // A drop taken into set A with its code and port
  sequence s_drop_into_a;
    capturable && !a_eff;
  endsequence

  sequence s_a_holds_drop;
    a_valid && a_reason == $past(drop_code) && a_port == $past(DROP_SRC_PORT);
  endsequence

  // A drop taken into set B while A is kept
  sequence s_drop_into_b;
    capturable && a_valid && !status_rd && !b_valid;
  endsequence

  sequence s_b_holds_drop;
    b_valid && a_valid && b_reason == $past(drop_code) && b_port == $past(DROP_SRC_PORT);
  endsequence

  // A drop in the same cycle as a status read lands in an emptied set A
  sequence s_read_with_drop;
    status_rd && capturable;
  endsequence

  sequence s_a_only_pending;
    a_valid && !b_valid && pend_reg;
  endsequence

  a_read_status_data: assert property ( // [R3]
    status_rd |=> RDATA == $past(status_word) ##1 RDATA == 32'h0 || $past(RD))
    else $error("status read data wrong or held too long");

  a_pending_set: assert property ( // [R3]
    DROP_VALID |=> pend_reg && status_word[0])
    else $error("pending bit not set by a drop");

  a_pending_clear: assert property ( // [R3]
    status_rd && !DROP_VALID |=> !pend_reg)
    else $error("pending bit survived a read");

  a_set_a_capture: assert property ( // [R5]
    s_drop_into_a |=> s_a_holds_drop)
    else $error("set A did not capture the drop");

  a_set_b_capture: assert property ( // [R1]
    s_drop_into_b |=> s_b_holds_drop)
    else $error("set B did not capture the second drop");

  a_both_full_hold: assert property ( // [R19]
    DROP_VALID && a_valid && b_valid && !status_rd |=> $stable(status_word[14:1]))
    else $error("full sets changed on a further drop");

  a_read_clears_sets: assert property ( // [R6]
    status_rd && !capturable |=> !a_valid && !b_valid && status_word[14:1] == 14'h0)
    else $error("capture sets not cleared by read");

  a_irq_masked: assert property ( // [R18]
    mask_reg |-> !IRQ)
    else $error("interrupt escaped the mask");

  a_irq_unmasked: assert property ( // [R2]
    !mask_reg && (|(evt_reg & evt_en_reg)) |-> IRQ)
    else $error("enabled event did not raise the interrupt");

  a_mask_after_reset: assert property ( // [R18]
    $rose(RST_N) |-> mask_reg && !pend_reg && !a_valid && !b_valid)
    else $error("wrong state after reset");

  a_port_never_rsvd: assert property ( // [R8]
    (a_valid |-> a_port != 2'h3) and (b_valid |-> b_port != 2'h3))
    else $error("reserved port code reported");

  a_reason_not_rsvd: assert property ( // [R17]
    a_valid |-> !(a_reason inside {4'hC, 4'hD, 4'hF}))
    else $error("reserved reason code reported");

  a_vlan_fff_code: assert property ( // [R17]
    s_drop_into_a and PKT_VLAN_ID_FFF |=> a_reason == 4'hE)
    else $error("VLAN FFF drop not coded 1110");

  a_upper_bits_zero: assert property ( // [R7]
    status_word[31:15] == 17'h0)
    else $error("reserved status bits not zero");

  // Fill order and event bookkeeping
  a_read_with_drop: assert property ( // [R19]
    s_read_with_drop |=> s_a_only_pending)
    else $error("drop beside a status read not kept in set A");

  a_no_load_full: assert property ( // [R19]
    a_valid && b_valid && !status_rd |-> !load_a && !load_b)
    else $error("a full pair of sets took another drop");

  a_loads_exclusive: assert property ( // [R1]
    !(load_a && load_b))
    else $error("one drop loaded into both sets");

  a_capt_event: assert property ( // [R19]
    load_a || load_b |=> evt_reg[sdes_pkg::SDES_EVT_CAPT])
    else $error("capture event not recorded");

  a_lost_event: assert property ( // [R19]
    drop_lost |=> evt_reg[sdes_pkg::SDES_EVT_LOST])
    else $error("lost drop event not recorded");

  // A clear write only wins when no new capture arrives with it
  a_evt_clear: assert property ( // [R2]
    WR && addr_hit(ADDR, sdes_pkg::SDES_ADDR_EVT_CLR) && WDATA[0] && !load_a && !load_b
    |=> !evt_reg[sdes_pkg::SDES_EVT_CAPT])
    else $error("capture event survived its clear");

  a_b_reason_legal: assert property ( // [R17]
    b_valid |-> !(b_reason inside {4'hC, 4'hD, 4'hF}))
    else $error("reserved reason code reported in set B");

  // Mask writes leave the status word untouched
  a_mask_write: assert property ( // [R18]
    WR && addr_hit(ADDR, sdes_pkg::SDES_ADDR_MASK) |=> mask_reg == $past(WDATA[0]))
    else $error("mask bit did not take the written value");

  a_mask_keeps_status: assert property ( // [R18]
    WR && addr_hit(ADDR, sdes_pkg::SDES_ADDR_MASK) && !DROP_VALID && !RD
    |=> $stable(status_word))
    else $error("mask write changed the status word");
endmodule // sdes_top

// file: dv/sdes_host_model.sv
// Host model: register bus master driving the block's register port
`timescale 1ns/1ps
module sdes_host_model (
  input wire logic clk,
  output logic [15:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd
);
  // Bus quiet at time zero
  initial
  begin
    addr = 16'h0000;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One write cycle; released lines show inverted values, not stale ones
  task automatic write(input logic [15:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    @(posedge clk);
  endtask

  // One read cycle; data is taken by the bench monitor a cycle later
  task automatic read(input logic [15:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge clk);
  endtask
endmodule // sdes_host_model

// file: dv/sdes_top_tb_top.sv
// Testbench for the drop event status block
`timescale 1ns/1ps
module sdes_top_tb_top;
  logic clk;
  logic rst_n;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic irq;
  logic drop_valid;
  logic [1:0] drop_port;
  logic [16:0] facts; // Config and packet facts, order as the instance below
  int n_fail;
  int tests_run;
  int cycles;
  int j;
  int k;
  logic [1:0] pa;
  logic [1:0] pb;
  logic rd_seen; // A read was taken; its data shows this cycle
  logic [31:0] exp_w; // Expected status word for the next read
  logic [31:0] exp_q [$]; // Expected read data, oldest first
  // Each row triggers exactly one drop cause on a healthy baseline
  logic [16:0] case_facts [13] = '{17'h1087C, 17'h08034, 17'h0005C, 17'h0006C,
    17'h08078, 17'h08074, 17'h0203C, 17'h0113C, 17'h002FC, 17'h0001C,
    17'h0007E, 17'h0007D, 17'h0047C};
  logic [3:0] case_code [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
    4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hE};

  sdes_host_model host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  sdes_top dut_u (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IRQ(irq), .DROP_VALID(drop_valid), .DROP_SRC_PORT(drop_port),
    .TAGGED_ONLY_ADMIT(facts[16]), .INGRESS_MEMBER_CHECK(facts[15]),
    .NONMEMBER_ADMIT(facts[14]), .UNKNOWN_UNICAST_DISCARD(facts[13]),
    .UNKNOWN_MULTICAST_DISCARD(facts[12]), .PKT_UNTAGGED_OR_PRIO(facts[11]),
    .PKT_VLAN_ID_FFF(facts[10]), .PKT_BCAST(facts[9]), .PKT_MCAST(facts[8]),
    .BCAST_OVER_LIMIT(facts[7]), .DST_FOUND(facts[6]), .SRC_FORWARDING(facts[5]),
    .DST_FORWARDING(facts[4]), .SRC_IN_VLAN(facts[3]), .DST_IN_VLAN(facts[2]),
    .SAME_PORT(facts[1]), .ENTRY_FILTER(facts[0]));

  // Free running clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Verdict and end of run
  task automatic end_of_test();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Compare one word or one bit
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Interrupt level looked at mid-cycle; returns on a rising edge so the
  // next bus or drop step changes its lines right after that edge
  task automatic chk_irq(input logic e);
    @(negedge clk);
    tests_run++;
    if (irq !== e)
    begin
      n_fail++;
      $display("[ERR] irq expected %b seen %b", e, irq);
    end
    @(posedge clk);
  endtask

  // Note the expected data, then issue the read
  task automatic rd_exp(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host_u.read(a);
  endtask

  // Present one drop for one edge; held so drops may follow back to back
  task automatic drop(input int c, input logic [1:0] p);
    drop_valid <= 1'b1;
    drop_port <= p;
    facts <= case_facts[c];
    @(posedge clk);
  endtask

  // Release the drop lines; stale facts shown inverted
  task automatic drop_end();
    drop_valid <= 1'b0;
    drop_port <= ~drop_port;
    facts <= ~facts;
  endtask

  // Status word with pending and set A valid; set B valid as given
  function automatic logic [31:0] st(input logic vb, input logic [3:0] ra,
    input logic [1:0] pa_i, input logic [3:0] rb, input logic [1:0] pb_i);
    return {17'h00000, rb, pb_i, vb, ra, pa_i, 1'b1, 1'b1};
  endfunction

  // Read data monitor: mid-cycle, once the registered data has settled
  always @(negedge clk)
  begin
    if (rd_seen)
    begin
      if (exp_q.size() == 0)
        chk32("unexpected read", 32'h00000000, 32'hFFFFFFFF);
      else
        chk32("rdata", exp_q.pop_front(), rdata);
    end
    rd_seen = rd;
  end

  // Hang guard; a full run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    drop_valid = 1'b0;
    drop_port = 2'h0;
    facts = 17'h00000;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    rd_seen = 1'b0;
    void'($urandom(32'h70D1));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values and an unmapped address
    rd_exp(sdes_pkg::SDES_ADDR_MASK, 32'h00000001);
    rd_exp(sdes_pkg::SDES_ADDR_STATUS, 32'h00000000);
    rd_exp(sdes_pkg::SDES_ADDR_EVT_EN, 32'h00000003);
    rd_exp(sdes_pkg::SDES_ADDR_EVT_CLR, 32'h00000000);
    rd_exp(16'h0000, 32'h00000000);
    // Every reason code, two captured back to back, a third one lost
    for (int i = 0; i < 13; i += 2)
    begin
      j = (i + 1) % 13;
      pa = 2'($urandom_range(2, 0));
      pb = 2'($urandom_range(2, 0));
      drop(i, pa);
      drop(j, pb);
      drop(i, pa);
      drop_end();
      chk_irq(1'b0);
      exp_w = st(1'b1, case_code[i], pa, case_code[j], pb);
      rd_exp(sdes_pkg::SDES_ADDR_STATUS, exp_w);
      rd_exp(sdes_pkg::SDES_ADDR_STATUS, 32'h00000000);
    end
    // Reserved port code is never reported
    drop(3, 2'h3);
    drop_end();
    rd_exp(sdes_pkg::SDES_ADDR_STATUS, 32'h00000001);
    rd_exp(sdes_pkg::SDES_ADDR_EVT, 32'h00000003);
    // Interrupt: unmask, enable, clear
    host_u.write(sdes_pkg::SDES_ADDR_MASK, 32'h00000000);
    chk_irq(1'b1);
    host_u.write(sdes_pkg::SDES_ADDR_EVT_EN, 32'h00000001);
    host_u.write(sdes_pkg::SDES_ADDR_EVT_CLR, 32'h00000001);
    chk_irq(1'b0);
    host_u.write(sdes_pkg::SDES_ADDR_EVT_EN, 32'h00000003);
    chk_irq(1'b1);
    host_u.write(sdes_pkg::SDES_ADDR_EVT_CLR, 32'h00000003);
    chk_irq(1'b0);
    rd_exp(sdes_pkg::SDES_ADDR_EVT, 32'h00000000);
    host_u.write(sdes_pkg::SDES_ADDR_MASK, 32'h00000001);
    drop(5, 2'h1);
    drop_end();
    chk_irq(1'b0);
    // Read in the same cycle as a drop: old word out, new drop kept
    fork
      rd_exp(sdes_pkg::SDES_ADDR_STATUS, st(1'b0, 4'h5, 2'h1, 4'h0, 2'h0));
      begin
        drop(12, 2'h2);
        drop_end();
      end
    join
    rd_exp(sdes_pkg::SDES_ADDR_STATUS, st(1'b0, 4'hE, 2'h2, 4'h0, 2'h0));
    // Random single drops land in set A
    repeat (24)
    begin
      k = $urandom_range(12, 0);
      pa = 2'($urandom_range(2, 0));
      drop(k, pa);
      drop_end();
      exp_w = st(1'b0, case_code[k], pa, 4'h0, 2'h0);
      rd_exp(sdes_pkg::SDES_ADDR_STATUS, exp_w);
    end
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule // sdes_top_tb_top
